// [verilog/flash_id_device.sv]
// flash end: identification readout, sleep gate and power-up write inhibit
// Contract
// - host sends 90h then 24-bit address zero
// - manufacturer then device byte, msb first
// - address 000001h swaps the two bytes
// - 9Fh returns manufacturer and two id bytes
// - id bytes are memory type then capacity
// - 24 bits right after eighth opcode bit
// - 9Fh ignored while erase or program runs
// - host avoids 9Fh during deep sleep
// - select high stops output, abandons read
// - select high returns to standby, await selection
// - writes rejected for 1 to 10 ms
// - erased array bytes read as FFh
// - status register delivered as 00h
// - deep sleep ignores all but release
`include "flash_id_params.svh"
module flash_id_device #(
	parameter logic [7:0]         MFR_CODE   = 8'h5a, // arbitrary value
	parameter logic [7:0]         DEV_CODE   = 8'h13, // arbitrary value
	parameter logic [7:0]         MEM_TYPE   = 8'h20, // arbitrary value
	parameter logic [7:0]         MEM_CAP    = 8'h14, // arbitrary value
	parameter logic [`WAIT_W-1:0] WRITE_WAIT = `WAIT_W'(`WRITE_WAIT_MIN_CYC)
) (
	input  wire logic  i_ref_clk,
	input  wire logic  i_reset,
	input  wire logic  i_clk_en,
	input  wire logic  i_busy,
	flash_link_if.device link,
	output logic       o_write_ready,
	output logic       o_deep_sleep,
	output logic [7:0] o_status,
	output logic [7:0] o_erased_byte
);
	import flash_id_pkg::*;

	dev_regs_t r_ff;
	dev_regs_t nxt_r;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// opcode decode on the byte just shifted in
	function automatic logic op_match(input logic [23:0] word, input logic [7:0] op);
		return word[7:0] == op;
	endfunction

	// three-byte identification word: maker, memory type, capacity
	function automatic logic [23:0] ident3_word();
		return {MFR_CODE, MEM_TYPE, MEM_CAP};
	endfunction

	// legacy pair, order picked by the address that came with it
	function automatic logic [23:0] legacy_word(input logic [23:0] addr);
		logic [23:0] word;
		if (addr == `ADDR_SWAPPED) begin
			word = {DEV_CODE, MFR_CODE, 8'h00};
		end else begin
			word = {MFR_CODE, DEV_CODE, 8'h00};
		end
		return word;
	endfunction

	// next output word: legacy rotates its 16-bit pair, 9Fh all 24 bits
	function automatic logic [23:0] rotate_out(input logic [23:0] w, input logic pair);
		logic [23:0] nw;
		if (pair) begin
			nw = {w[22:8], w[23], 8'h00};
		end else begin
			nw = {w[22:0], w[23]};
		end
		return nw;
	endfunction

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		logic sel_n;
		logic rise;
		logic fall;
		logic [23:0] sh;
		sel_n = r_ff.sel_sync[1];
		// edges of the synchronised link clock
		rise = r_ff.clk_sync[1] & ~r_ff.sclk_prev;
		fall = ~r_ff.clk_sync[1] & r_ff.sclk_prev;
		sh = {r_ff.shin[22:0], r_ff.si_sync[1]};
		nxt_r = r_ff;

		// two-stage synchronisers on every link input
		nxt_r.clk_sync = {r_ff.clk_sync[0], link.sclk};
		nxt_r.sel_sync = {r_ff.sel_sync[0], link.select_n};
		nxt_r.si_sync = {r_ff.si_sync[0], link.serial_in};
		nxt_r.sclk_prev = r_ff.clk_sync[1];

		// power-up write inhibit timer
		if (r_ff.wait_cnt != WRITE_WAIT) begin
			nxt_r.wait_cnt = r_ff.wait_cnt + `WAIT_W'(1);
		end
		nxt_r.write_ready = (r_ff.wait_cnt == WRITE_WAIT);

		if (sel_n) begin
			// deselect: release line, run armed one-byte commands
			nxt_r.so_oe = 1'b0;
			nxt_r.state = DEV_IDLE;
			if (r_ff.arm_sleep) begin
				nxt_r.sleeping = 1'b1;
			end
			if (r_ff.arm_wake) begin
				nxt_r.sleeping = 1'b0;
			end
			nxt_r.arm_sleep = 1'b0;
			nxt_r.arm_wake = 1'b0;
		end else begin
			case (r_ff.state)
				DEV_IDLE: begin
					// new selection: start a fresh instruction
					nxt_r.state = DEV_OPCODE;
					nxt_r.bit_cnt = 6'h00;
				end
				DEV_OPCODE: begin
					// opcode shifts in msb first on detected rises
					if (rise) begin
						nxt_r.shin = sh;
						nxt_r.bit_cnt = r_ff.bit_cnt + 6'h01;
						if (r_ff.bit_cnt == `OPCODE_BITS - 6'h01) begin
							nxt_r.state = DEV_SKIP;
							nxt_r.bit_cnt = 6'h00;
							if (r_ff.sleeping) begin
								// asleep: only the release opcode is heard
								nxt_r.arm_wake = op_match(sh, `OP_WAKE);
							end else if (op_match(sh, `OP_IDENT3) && !i_busy) begin
								nxt_r.shout = ident3_word();
								nxt_r.legacy = 1'b0;
								nxt_r.state = DEV_OUT;
							end else if (op_match(sh, `OP_LEGACY_ID)) begin
								nxt_r.state = DEV_ADDR;
							end else if (op_match(sh, `OP_SLEEP)) begin
								// sleep refused while erase or program runs
								nxt_r.arm_sleep = !i_busy;
							end else if (op_match(sh, `OP_WAKE)) begin
								nxt_r.arm_wake = 1'b1;
							end
						end
					end
				end
				DEV_ADDR: begin
					if (rise) begin
						nxt_r.shin = sh;
						nxt_r.bit_cnt = r_ff.bit_cnt + 6'h01;
						if (r_ff.bit_cnt == `ADDR_BITS - 6'h01) begin
							nxt_r.state = DEV_OUT;
							nxt_r.legacy = 1'b1;
							// pair order follows the address just taken
							nxt_r.shout = legacy_word(sh);
						end
					end
				end
				DEV_OUT: begin
					// one bit per falling edge, msb first
					if (fall) begin
						nxt_r.so = r_ff.shout[23];
						nxt_r.so_oe = 1'b1;
						nxt_r.shout = rotate_out(r_ff.shout, r_ff.legacy);
					end
				end
				DEV_SKIP: begin
					// any clock after a one-byte command cancels it
					if (rise) begin
						nxt_r.arm_sleep = 1'b0;
						nxt_r.arm_wake = 1'b0;
					end
				end
				default: begin
					nxt_r.state = DEV_IDLE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			r_ff <= '0;
			r_ff.clk_sync <= 2'h0;
			r_ff.sel_sync <= 2'h3;
			r_ff.state <= DEV_IDLE;
			r_ff.status <= `STATUS_DELIVERY;
			r_ff.erased <= `ARRAY_ERASED;
		end else if (i_clk_en) begin
			r_ff <= nxt_r;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	// every output straight from the state register
	assign link.serial_out = r_ff.so;
	assign link.serial_out_oe = r_ff.so_oe;
	assign o_write_ready = r_ff.write_ready;
	assign o_deep_sleep = r_ff.sleeping;
	assign o_status = r_ff.status;
	assign o_erased_byte = r_ff.erased;

endmodule // flash_id_device

// [inc/flash_id_params.svh]
// constants shared by both ends of the identification readout link
`ifndef FLASH_ID_PARAMS_SVH
`define FLASH_ID_PARAMS_SVH

// ----------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------
`define CLK_MHZ             50
`define WRITE_WAIT_MIN_US   1000
`define WRITE_WAIT_MAX_US   10000
`define WRITE_WAIT_MIN_CYC  (`WRITE_WAIT_MIN_US * `CLK_MHZ)
`define WRITE_WAIT_MAX_CYC  (`WRITE_WAIT_MAX_US * `CLK_MHZ)
`define WAIT_W              19
`define SCLK_HALF           4'h7
`define SCLK_LAST           4'hf

// ----------------------------------------------------------------
// opcodes, addresses, frame lengths
// ----------------------------------------------------------------
`define OP_LEGACY_ID        8'h90
`define OP_IDENT3           8'h9f
`define OP_SLEEP            8'hb9
`define OP_WAKE             8'hab
`define ADDR_SWAPPED        24'h000001
`define OPCODE_BITS         6'h08
`define ADDR_BITS           6'h18
`define LEGACY_FRAME_BITS   6'h30
`define IDENT3_FRAME_BITS   6'h20

// ----------------------------------------------------------------
// delivery state
// ----------------------------------------------------------------
`define ARRAY_ERASED        8'hff
`define STATUS_DELIVERY     8'h00

`endif

// [inc/flash_id_pkg.sv]
// types shared by both ends of the identification readout link
package flash_id_pkg;
`include "flash_id_params.svh"

	// ------------------------------------------------------------
	// device end
	// ------------------------------------------------------------
	typedef enum logic [4:0] {
		DEV_IDLE   = 5'h01,
		DEV_OPCODE = 5'h02,
		DEV_ADDR   = 5'h04,
		DEV_OUT    = 5'h08,
		DEV_SKIP   = 5'h10
	} dev_state_t;

	typedef struct packed {
		logic [1:0]         clk_sync;
		logic [1:0]         sel_sync;
		logic [1:0]         si_sync;
		logic               sclk_prev;
		dev_state_t         state;
		logic [5:0]         bit_cnt;
		logic [23:0]        shin;
		logic [23:0]        shout;
		logic               legacy;
		logic               arm_sleep;
		logic               arm_wake;
		logic               sleeping;
		logic               so;
		logic               so_oe;
		logic [`WAIT_W-1:0] wait_cnt;
		logic               write_ready;
		logic [7:0]         status;
		logic [7:0]         erased;
	} dev_regs_t;

	// ------------------------------------------------------------
	// host end
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		HST_IDLE = 3'h1,
		HST_RUN  = 3'h2,
		HST_GAP  = 3'h4
	} host_state_t;

	typedef struct packed {
		logic [1:0]         so_sync;
		host_state_t        state;
		logic [3:0]         ph;
		logic [5:0]         bit_idx;
		logic [5:0]         nbits;
		logic [5:0]         ntx;
		logic [31:0]        tx;
		logic [23:0]        rx;
		logic               sel_n;
		logic               sclk;
		logic               mosi;
		logic [`WAIT_W-1:0] wait_cnt;
		logic               write_allowed;
		logic               done;
		logic               refused;
		logic               busy;
		logic [23:0]        id;
	} host_regs_t;

endpackage

// [inc/flash_link_if.sv]
// serial link between the host controller and the flash identification end
interface flash_link_if;
	logic select_n;
	logic sclk;
	logic serial_in;
	logic serial_out;
	logic serial_out_oe;
	logic serial_line;

	// undriven line floats high through the board pull-up
	assign serial_line = serial_out_oe ? serial_out : 1'b1;

	modport device (
		input  select_n,
		input  sclk,
		input  serial_in,
		output serial_out,
		output serial_out_oe
	);

	modport host (
		output select_n,
		output sclk,
		output serial_in,
		input  serial_line
	);
endinterface

// [verilog/flash_id_host.sv]
// host end: runs one identification read per request over the serial link
`include "flash_id_params.svh"
module flash_id_host #(
	parameter logic [`WAIT_W-1:0] WRITE_WAIT = `WAIT_W'(`WRITE_WAIT_MAX_CYC)
) (
	input  wire logic   i_ref_clk,
	input  wire logic   i_reset,
	input  wire logic   i_clk_en,
	input  wire logic   i_start,
	input  wire logic   i_ident3,
	input  wire logic   i_swap,
	input  wire logic   i_abort,
	input  wire logic   i_target_asleep,
	flash_link_if.host  link,
	output logic        o_busy,
	output logic        o_done,
	output logic        o_refused,
	output logic [23:0] o_id,
	output logic        o_write_allowed
);
	import flash_id_pkg::*;

	host_regs_t r_ff;
	host_regs_t nxt_r;

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		nxt_r = r_ff;
		nxt_r.so_sync = {r_ff.so_sync[0], link.serial_line};
		nxt_r.done = 1'b0;
		nxt_r.refused = 1'b0;

		// write instructions held back until the longest wait
		if (r_ff.wait_cnt != WRITE_WAIT) begin
			nxt_r.wait_cnt = r_ff.wait_cnt + `WAIT_W'(1);
		end
		nxt_r.write_allowed = (r_ff.wait_cnt == WRITE_WAIT);

		case (r_ff.state)
			HST_IDLE: begin
				if (i_start && i_target_asleep) begin
					nxt_r.refused = 1'b1;
				end else if (i_start) begin
					nxt_r.state = HST_RUN;
					nxt_r.busy = 1'b1;
					nxt_r.sel_n = 1'b0;
					nxt_r.ph = 4'h0;
					nxt_r.bit_idx = 6'h00;
					if (i_ident3) begin
						nxt_r.tx = {`OP_IDENT3, 24'h000000};
						nxt_r.ntx = `OPCODE_BITS;
						nxt_r.nbits = `IDENT3_FRAME_BITS;
						nxt_r.mosi = nxt_r.tx[31]; // opcode msb leads
					end else begin
						nxt_r.tx = {`OP_LEGACY_ID, i_swap ? `ADDR_SWAPPED : 24'h000000};
						nxt_r.ntx = `OPCODE_BITS + `ADDR_BITS;
						nxt_r.nbits = `LEGACY_FRAME_BITS;
						nxt_r.mosi = nxt_r.tx[31]; // opcode msb leads
					end
				end
			end
			HST_RUN: begin
				nxt_r.ph = r_ff.ph + 4'h1;
				if (i_abort) begin
					// deselect mid-frame drops the read
					nxt_r.state = HST_GAP;
					nxt_r.sel_n = 1'b1;
					nxt_r.sclk = 1'b0;
					nxt_r.ph = 4'h0;
				end else if (r_ff.ph == `SCLK_HALF) begin
					nxt_r.sclk = 1'b1;
					if (r_ff.bit_idx >= r_ff.ntx) begin
						nxt_r.rx = {r_ff.rx[22:0], r_ff.so_sync[1]};
					end
				end else if (r_ff.ph == `SCLK_LAST) begin
					nxt_r.sclk = 1'b0;
					nxt_r.tx = {r_ff.tx[30:0], 1'b0};
					nxt_r.mosi = r_ff.tx[30];
					nxt_r.bit_idx = r_ff.bit_idx + 6'h01;
					if (r_ff.bit_idx == r_ff.nbits - 6'h01) begin
						nxt_r.state = HST_GAP;
						nxt_r.sel_n = 1'b1;
						nxt_r.done = 1'b1;
						nxt_r.id = (r_ff.ntx == `OPCODE_BITS) ? r_ff.rx
							: {8'h00, r_ff.rx[15:0]};
					end
				end
			end
			HST_GAP: begin
				// select high for one bit time before the next frame
				nxt_r.ph = r_ff.ph + 4'h1;
				nxt_r.mosi = 1'b0;
				if (r_ff.ph == `SCLK_LAST) begin
					nxt_r.state = HST_IDLE;
					nxt_r.busy = 1'b0;
				end
			end
			default: begin
				nxt_r.state = HST_IDLE;
			end
		endcase
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			r_ff <= '0;
			r_ff.so_sync <= 2'h3;
			r_ff.state <= HST_IDLE;
			r_ff.sel_n <= 1'b1;
		end else if (i_clk_en) begin
			r_ff <= nxt_r;
		end
	end

	assign link.select_n = r_ff.sel_n;
	assign link.sclk = r_ff.sclk;
	assign link.serial_in = r_ff.mosi;
	assign o_busy = r_ff.busy;
	assign o_done = r_ff.done;
	assign o_refused = r_ff.refused;
	assign o_id = r_ff.id;
	assign o_write_allowed = r_ff.write_allowed;

endmodule // flash_id_host

// [verif/flash_id_readout_properties.sv]
// link-level assertions for the identification readout link
`include "flash_id_params.svh"
module flash_id_readout_properties (
	input wire logic i_ref_clk,
	input wire logic i_reset,
	input wire logic i_select_n,
	input wire logic i_sclk,
	input wire logic i_serial_in,
	input wire logic i_serial_out,
	input wire logic i_serial_out_oe,
	input wire logic i_serial_line
);
	timeunit 1ns;
	timeprecision 1ps;

	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_reset);

	logic [5:0] rise_cnt_ff;
	logic [7:0] op_ff;
	logic       sclk_prev_ff;

	// count clock rises in a frame and capture the opcode
	always_ff @(posedge i_ref_clk) begin
		sclk_prev_ff <= i_sclk;
		if (i_reset || i_select_n) begin
			rise_cnt_ff <= 6'h00;
			op_ff       <= 8'h00;
		end else if (i_sclk && !sclk_prev_ff) begin
			if (rise_cnt_ff != 6'h3f) begin
				rise_cnt_ff <= rise_cnt_ff + 6'h01;
			end
			if (rise_cnt_ff < `OPCODE_BITS) begin
				op_ff <= {op_ff[6:0], i_serial_in};
			end
		end
	end

	sequence s_clk_low4;
		!i_sclk [*4];
	endsequence

	sequence s_clk_high4;
		i_sclk [*4];
	endsequence

	a_oe_needs_cmd: assert property ($rose(i_serial_out_oe) |->
		(rise_cnt_ff == `OPCODE_BITS && op_ff == `OP_IDENT3) ||
		(rise_cnt_ff == `OPCODE_BITS + `ADDR_BITS && op_ff == `OP_LEGACY_ID))
		else $error("output enabled without a complete read command");
	a_oe_starts_low: assert property ($rose(i_serial_out_oe) |-> !i_sclk)
		else $error("output started while clock high");
	a_out_steady_high: assert property (i_serial_out_oe && i_sclk && $past(i_sclk) |->
		$stable(i_serial_out))
		else $error("output changed while clock high");
	a_oe_released: assert property ($rose(i_select_n) |-> ##[1:4] !i_serial_out_oe)
		else $error("output still driven after deselect");
	a_idle_no_drive: assert property (i_select_n [*5] |-> !i_serial_out_oe)
		else $error("output driven while deselected");
	a_line_idle_high: assert property (i_select_n [*5] |-> i_serial_line)
		else $error("line not released after deselect");
	a_select_clk_low: assert property ($fell(i_select_n) |-> s_clk_low4)
		else $error("clock not low after select");
	a_sclk_high_time: assert property ($rose(i_sclk) |-> s_clk_high4)
		else $error("clock high phase too short");
	a_sclk_low_time: assert property ($fell(i_sclk) && !i_select_n |-> s_clk_low4)
		else $error("clock low phase too short");
	a_no_clk_idle: assert property (i_select_n && $past(i_select_n) |-> !i_sclk)
		else $error("clock toggles while deselected");
endmodule // flash_id_readout_properties

// [verif/flash_id_readout_test.sv]
// self-checking bench joining host and flash ends
module flash_id_readout_test;
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [7:0] MFR  = 8'ha6; // arbitrary value
	localparam logic [7:0] DEVC = 8'h3c; // arbitrary value
	localparam logic [7:0] TYP  = 8'h41; // arbitrary value
	localparam logic [7:0] CAP  = 8'h17; // arbitrary value

	logic        clk = 1'b0, rst = 1'b1, busy = 1'b0, start = 1'b0;
	logic        ident3 = 1'b0, swap = 1'b0, abort = 1'b0, asleep = 1'b0;
	logic        en = 1'b1;
	int          freeze_at = -1;
	logic        rdy, dsl, hb, hd, hr, hw;
	logic [7:0]  st, er;
	logic [23:0] id;
	int          num_errors = 0, total_checks = 0, seed = 32'hef304432;

	flash_link_if link ();
	flash_id_device #(.MFR_CODE(MFR), .DEV_CODE(DEVC), .MEM_TYPE(TYP), .MEM_CAP(CAP),
		.WRITE_WAIT(19'h14)) u_flash_id_device (.i_ref_clk(clk), .i_reset(rst),
		.i_clk_en(en), .i_busy(busy), .link(link.device), .o_write_ready(rdy),
		.o_deep_sleep(dsl), .o_status(st), .o_erased_byte(er));
	flash_id_host #(.WRITE_WAIT(19'h28)) u_flash_id_host (.i_ref_clk(clk), .i_reset(rst),
		.i_clk_en(en), .i_start(start), .i_ident3(ident3), .i_swap(swap), .i_abort(abort),
		.i_target_asleep(asleep), .link(link.host), .o_busy(hb), .o_done(hd),
		.o_refused(hr), .o_id(id), .o_write_allowed(hw));
	flash_id_readout_properties u_props (.i_ref_clk(clk), .i_reset(rst),
		.i_select_n(link.select_n), .i_sclk(link.sclk), .i_serial_in(link.serial_in),
		.i_serial_out(link.serial_out), .i_serial_out_oe(link.serial_out_oe),
		.i_serial_line(link.serial_line));

	// 50 MHz clock
	initial begin
		forever #10 clk = ~clk;
	end

	task automatic check(input logic ok, input string msg);
		total_checks++;
		if (ok !== 1'b1) begin
			num_errors++;
			$display("mismatch at %0t: %s", $time, msg);
		end
	endtask

	task automatic end_of_test;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// expected identification word as the host reports it
	function automatic logic [23:0] expect_id(input logic i3, input logic sw, input logic bsy);
		if (i3) return bsy ? 24'hffffff : {MFR, TYP, CAP};
		return sw ? {8'h00, DEVC, MFR} : {8'h00, MFR, DEVC};
	endfunction

	// one read request; abort raised at cycle cut, flags seen until busy drops
	task automatic read(input logic i3, input logic sw, input int cut,
		output logic dn, output logic rf);
		int n;
		dn = 1'b0;
		rf = 1'b0;
		@(negedge clk);
		ident3 = i3;
		swap = sw;
		start = 1'b1;
		@(negedge clk);
		start = 1'b0;
		for (n = 0; n < 1000; n++) begin
			if (n == freeze_at) en = 1'b0;
			if (n == freeze_at + 12) en = 1'b1;
			if (n == cut) abort = 1'b1;
			if (hd === 1'b1) dn = 1'b1;
			if (hr === 1'b1) rf = 1'b1;
			if (n > 1 && hb !== 1'b1) break;
			@(negedge clk);
		end
		abort = 1'b0;
		if (n == 1000) check(1'b0, "read never finished");
	endtask

	// main sequence
	initial begin
		int   i;
		logic dn, rf, i3, sw;
		repeat (16) @(negedge clk);
		rst = 1'b0;
		@(negedge clk);
		check(st === 8'h00, "status delivery value");
		check(er === 8'hff, "erased byte value");
		check(rdy === 1'b0 && hw === 1'b0 && dsl === 1'b0, "write inhibit at start");
		repeat (30) @(negedge clk);
		check(rdy === 1'b1 && hw === 1'b0, "device inhibit over, host waiting");
		repeat (15) @(negedge clk);
		check(hw === 1'b1, "host wait over");
		// corner combinations first, then random, back to back
		for (i = 0; i < 9; i++) begin
			i3 = 1'($random(seed));
			sw = 1'($random(seed));
			if (i < 4) begin
				i3 = i[0];
				sw = i[1];
			end
			read(i3, sw, 2000, dn, rf);
			check(dn === 1'b1 && id === expect_id(i3, sw, 1'b0), "id read");
		end
		// clock enable dropped mid-frame: both ends hold, frame still completes
		freeze_at = 200;
		read(1'b0, 1'b0, 2000, dn, rf);
		check(dn === 1'b1 && id === expect_id(1'b0, 1'b0, 1'b0), "read across hold");
		freeze_at = -1;
		// program or erase running: only the three-byte read is gated
		busy = 1'b1;
		read(1'b1, 1'b0, 2000, dn, rf);
		check(id === expect_id(1'b1, 1'b0, 1'b1), "three-byte read while busy");
		read(1'b0, 1'b1, 2000, dn, rf);
		check(id === expect_id(1'b0, 1'b1, 1'b0), "legacy read while busy");
		busy = 1'b0;
		// deselect in mid output, then a clean read
		read(1'b1, 1'b0, 300, dn, rf);
		check(dn === 1'b0 && id === expect_id(1'b0, 1'b1, 1'b0), "aborted read");
		read(1'b1, 1'b0, 2000, dn, rf);
		check(id === expect_id(1'b1, 1'b0, 1'b0), "read after abort");
		// target asleep: request refused
		asleep = 1'b1;
		read(1'b1, 1'b0, 2000, dn, rf);
		check(rf === 1'b1 && dn === 1'b0, "request refused");
		asleep = 1'b0;
		// second reset in mid-run: delivery state and write inhibit come back
		rst = 1'b1;
		repeat (16) @(negedge clk);
		rst = 1'b0;
		@(negedge clk);
		check(rdy === 1'b0 && hw === 1'b0 && id === 24'h000000, "inhibit after reset");
		check(st === 8'h00 && er === 8'hff && dsl === 1'b0, "state after reset");
		read(1'b1, 1'b0, 2000, dn, rf);
		check(dn === 1'b1 && id === expect_id(1'b1, 1'b0, 1'b0), "read after reset");
		end_of_test;
	end

	// watchdog
	initial begin
		#(60000 * 20);
		num_errors++;
		$display("mismatch at %0t: watchdog expired", $time);
		end_of_test;
	end
endmodule // flash_id_readout_test
